/* File: verilog/bss_defs.svh */
// Constants of the buck start-up sequencer: timing, levels, offsets and field positions.
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

// Clock of the block, 20 MHz.
`define BSS_CLK_NS 50
// Soft-start stepping clock, 200 kHz.
`define BSS_SS_CLK_NS 5000
`define BSS_SS_TICK_CYC (`BSS_SS_CLK_NS / `BSS_CLK_NS)
// Soft-start slope, 0.4 mV/us, in uV per us; step in mV per soft-start tick.
`define BSS_SS_SLOPE_UV_US 400
`define BSS_SS_STEP_INT ((`BSS_SS_SLOPE_UV_US * `BSS_SS_CLK_NS) / 1000000)
// Soft-start levels in mV: final 1500, tracking window 150 to 750.
`define BSS_SS_FINAL_MV 11'h5DC
`define BSS_TRACK_LO_MV 11'h096
`define BSS_TRACK_HI_MV 11'h2EE
`define BSS_SS_ZERO_MV 11'h000
// Over-voltage propagation delay, 2.5 us typical.
`define BSS_OVP_DELAY_NS 2500
`define BSS_OVP_DELAY_CYC (`BSS_OVP_DELAY_NS / `BSS_CLK_NS)
// Hiccup blanking, 20.48 ms typical.
`define BSS_HICCUP_NS 20480000
`define BSS_HICCUP_CYC (`BSS_HICCUP_NS / `BSS_CLK_NS)
// Pre-bias start-up: 16 pulses per step, 8 steps of one eighth.
`define BSS_PB_PULSES 16
`define BSS_PB_LAST_PULSE 4'hF
`define BSS_PB_FIRST_STEP 4'h1
`define BSS_PB_LAST_STEP 4'h8
// Valley over-current level select codes: 21 A, 16.5 A, 12.5 A.
`define BSS_OC_HIGH 2'h2
`define BSS_OC_MID 2'h1
`define BSS_OC_LOW 2'h0
// Register offsets.
`define BSS_ADDR_STATUS 4'h0
`define BSS_ADDR_MASK 4'h4
`define BSS_ADDR_STATE 4'h8
// Event bits of the status and mask registers.
`define BSS_EV_W 5
`define BSS_EV_VALID 0
`define BSS_EV_OC 1
`define BSS_EV_OVP 2
`define BSS_EV_HOT 3
`define BSS_EV_DONE 4

`endif

/* File: verilog/bss_pkg.sv */
// Types of the buck start-up sequencer.
`include "bss_defs.svh"
package bss_pkg;

   typedef enum logic [4:0] {
      BSS_LOCKOUT = 5'h01,
      BSS_RAMP    = 5'h02,
      BSS_RUN     = 5'h04,
      BSS_HICCUP  = 5'h08,
      BSS_THERMAL = 5'h10
   } bss_state_e;

   typedef struct packed {
      bss_state_e state;
      logic valid;
      logic [18:0] hiccup_cnt;
      logic [5:0] ovp_cnt;
      logic ovp_fault;
      logic oc_fault;
      logic hs_on;
      logic ls_on;
      logic [3:0] ls_eighths;
      logic [1:0] oc_sel;
      logic bias_hi;
      logic ramping;
      logic [`BSS_EV_W-1:0] status;
      logic [`BSS_EV_W-1:0] mask;
      logic [15:0] rdata;
      logic irq;
   } bss_top_s;

   typedef struct packed {
      logic [6:0] tick;
      logic [10:0] level;
   } bss_ramp_s;

   typedef struct packed {
      logic seen_hs;
      logic [3:0] pulse_cnt;
      logic [3:0] step;
      logic done;
   } bss_pb_s;

endpackage

/* File: verilog/bss_seq_if.sv */
// Signals between the sequencer control and its ramp and pre-bias stepping modules.
interface bss_seq_if;
   logic ss_run;
   logic ss_clear;
   logic [10:0] ss_level;
   logic pb_clear;
   logic period_tick;
   logic hs_pulse;
   logic pb_ls_allow;
   logic [3:0] pb_eighths;
   logic pb_done;

   modport ctrl (
      output ss_run, ss_clear, pb_clear, period_tick, hs_pulse,
      input ss_level, pb_ls_allow, pb_eighths, pb_done
   );
   modport ramp (
      input ss_run, ss_clear,
      output ss_level
   );
   modport prebias (
      input pb_clear, period_tick, hs_pulse,
      output pb_ls_allow, pb_eighths, pb_done
   );
endinterface

/* File: verilog/bss_softstart.sv */
// Digital soft-start reference: fixed steps on an internal 200 kHz tick.
`include "bss_defs.svh"
module bss_softstart (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Sequencer side.
   bss_seq_if.ramp seq
);
   localparam int TICK_CYC = `BSS_SS_TICK_CYC;
   localparam int STEP_MV = `BSS_SS_STEP_INT;
   localparam bss_pkg::bss_ramp_s RST = '{default: '0};

   bss_pkg::bss_ramp_s ramp_reg;
   bss_pkg::bss_ramp_s ramp_next;

   always_comb begin
      ramp_next = ramp_reg;
      if (seq.ss_clear) begin
         ramp_next = RST;
      end else if (seq.ss_run) begin
         if (ramp_reg.tick == 7'(TICK_CYC - 1)) begin
            ramp_next.tick = '0;
            // [R6] linear digital stepping
            if (ramp_reg.level < `BSS_SS_FINAL_MV) begin
               ramp_next.level = ramp_reg.level + 11'(STEP_MV);
            end
         end else begin
            ramp_next.tick = ramp_reg.tick + 7'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ramp_reg <= RST;
      end else begin
         ramp_reg <= ramp_next;
      end
   end

   assign seq.ss_level = ramp_reg.level;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   ramp_step_a: assert property ( // [R6]
      seq.ss_level != $past(seq.ss_level) && !$past(seq.ss_clear)
      |-> seq.ss_level == $past(seq.ss_level) + 11'(STEP_MV)
          && $past(ramp_reg.tick) == 7'(TICK_CYC - 1))
      else $error("soft-start level moved off its tick or step");

   ramp_ceiling_a: assert property ( // [R6]
      seq.ss_level <= `BSS_SS_FINAL_MV)
      else $error("soft-start level above final level");
endmodule

/* File: verilog/bss_prebias.sv */
// Pre-bias start-up: low-side width grows one eighth per 16 switching periods.
`include "bss_defs.svh"
module bss_prebias (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Sequencer side.
   bss_seq_if.prebias seq
);
   localparam bss_pkg::bss_pb_s RST = '{step: `BSS_PB_FIRST_STEP, default: '0};

   bss_pkg::bss_pb_s pb_reg;
   bss_pkg::bss_pb_s pb_next;

   always_comb begin
      pb_next = pb_reg;
      if (seq.pb_clear) begin
         pb_next = RST;
      // [R3] wait first high-side pulse
      end else if (!pb_reg.seen_hs) begin
         pb_next.seen_hs = seq.hs_pulse;
      // [R15] count switching periods
      end else if (seq.period_tick && !pb_reg.done) begin
         pb_next.pulse_cnt = pb_reg.pulse_cnt + 4'h1;
         // [R5] sixteen pulses per step
         if (pb_reg.pulse_cnt == `BSS_PB_LAST_PULSE) begin
            // [R4] widen by one eighth
            if (pb_reg.step == `BSS_PB_LAST_STEP) begin
               pb_next.done = 1'b1;
            end else begin
               pb_next.step = pb_reg.step + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pb_reg <= RST;
      end else begin
         pb_reg <= pb_next;
      end
   end

   assign seq.pb_ls_allow = pb_reg.seen_hs;
   assign seq.pb_eighths = pb_reg.step;
   assign seq.pb_done = pb_reg.done;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   step_after_sixteen_a: assert property ( // [R5]
      seq.pb_eighths != $past(seq.pb_eighths) && !$past(seq.pb_clear)
      |-> $past(pb_reg.pulse_cnt) == `BSS_PB_LAST_PULSE && $past(seq.period_tick)
          && seq.pb_eighths == $past(seq.pb_eighths) + 4'h1)
      else $error("pre-bias step changed off the sixteenth pulse");

   first_eighth_a: assert property ( // [R4]
      $past(seq.pb_clear) |-> seq.pb_eighths == `BSS_PB_FIRST_STEP && !seq.pb_ls_allow)
      else $error("pre-bias did not restart at one eighth");
endmodule

/* File: verilog/bss_top.sv */
// Start-up and protection sequencer of a synchronous buck controller.
//
// Decided for this implementation: the strobed register port and the address map.
`include "bss_defs.svh"

// How it works
// [R1] Drivers off while bias or enable low.
// [R2] Supply valid when all lockouts pass; starts ramp.
// [R3] Low side off until first high-side pulse.
// [R4] Low-side width starts one eighth, grows eighths.
// [R5] Sixteen pulses per step, eight steps.
// [R6] Soft-start rises linearly by digital steps.
// [R7] Output ramps between 150 and 750 mV.
// [R8] Over-current and over-voltage active during ramp.
// [R9] Over-voltage flagged after 2.5 us delay.
// [R10] Three-state pin picks valley current limit.
// [R11] Light load selects lower gate-drive bias.
// [R12] Over-current: hiccup with zero level, retry.
// [R13] Over-temperature: switches off, reset, auto restart.
// [R14] Supply loss resets ramp and step counter.
// [R15] Pulse counter advances once per period.
module bss_top #(
   parameter int HICCUP_CYC = `BSS_HICCUP_CYC
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Lockout and fault comparators.
   input wire logic bias_ok_i,
   input wire logic enable_ok_i,
   input wire logic overtemp_i,
   input wire logic ovp_above_i,
   input wire logic oc_event_i,
   // Power stage timing and load.
   input wire logic period_start_i,
   input wire logic hs_pwm_i,
   input wire logic light_load_i,
   // Three-state trip level pin comparators.
   input wire logic trip_pin_high_i,
   input wire logic trip_pin_low_i,
   // Register port.
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [15:0] reg_rdata_o,
   output logic irq_o,
   // Driver and status outputs.
   output logic high_side_switch_o,
   output logic low_side_switch_o,
   output logic [3:0] low_side_eighths_o,
   output logic supply_valid_o,
   output logic output_ramping_o,
   output logic oc_fault_o,
   output logic ovp_fault_o,
   output logic [1:0] trip_level_select_o,
   output logic gate_bias_high_o
);
   localparam int OVP_CYC = `BSS_OVP_DELAY_CYC;
   localparam bss_pkg::bss_top_s RST = '{state: bss_pkg::BSS_LOCKOUT, default: '0};

   bss_seq_if seq ();

   bss_pkg::bss_top_s top_reg;
   bss_pkg::bss_top_s top_next;

   logic supply_ok;
   logic active_reg;
   logic active_next;
   logic [`BSS_EV_W-1:0] event_set;

   assign supply_ok = bias_ok_i & enable_ok_i;
   assign active_reg = (top_reg.state == bss_pkg::BSS_RAMP) ||
                       (top_reg.state == bss_pkg::BSS_RUN);

   // [R12] level held at zero outside ramp and run
   assign seq.ss_run = active_reg;
   assign seq.ss_clear = !active_reg;
   // [R14] restart pre-bias stepping
   assign seq.pb_clear = !active_reg;
   assign seq.period_tick = period_start_i;
   assign seq.hs_pulse = hs_pwm_i & active_reg;

   bss_softstart u_softstart (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .seq(seq.ramp)
   );

   bss_prebias u_prebias (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .seq(seq.prebias)
   );

   always_comb begin
      top_next = top_reg;
      event_set = '0;
      active_next = 1'b0;
      top_next.valid = supply_ok;

      // [R9] over-voltage after propagation delay
      if (ovp_above_i) begin
         if (top_reg.ovp_cnt == 6'(OVP_CYC - 1)) begin
            top_next.ovp_fault = 1'b1;
         end else begin
            top_next.ovp_cnt = top_reg.ovp_cnt + 6'h01;
         end
      end else begin
         top_next.ovp_cnt = '0;
         top_next.ovp_fault = 1'b0;
      end
      event_set[`BSS_EV_OVP] = top_next.ovp_fault & !top_reg.ovp_fault;

      // [R10] valley limit from three-state pin
      if (trip_pin_high_i) begin
         top_next.oc_sel = `BSS_OC_HIGH;
      end else if (trip_pin_low_i) begin
         top_next.oc_sel = `BSS_OC_LOW;
      end else begin
         top_next.oc_sel = `BSS_OC_MID;
      end

      // [R11] gate-drive bias level
      top_next.bias_hi = !light_load_i;

      // [R1] lockout overrides every state
      if (!supply_ok) begin
         top_next.state = bss_pkg::BSS_LOCKOUT;
         top_next.oc_fault = 1'b0;
         top_next.hiccup_cnt = '0;
      end else begin
         unique case (top_reg.state)
            bss_pkg::BSS_LOCKOUT: begin
               // [R2] supply valid starts soft-start
               top_next.state = bss_pkg::BSS_RAMP;
               event_set[`BSS_EV_VALID] = 1'b1;
            end
            bss_pkg::BSS_RAMP, bss_pkg::BSS_RUN: begin
               // [R13] thermal shutdown
               if (overtemp_i) begin
                  top_next.state = bss_pkg::BSS_THERMAL;
                  event_set[`BSS_EV_HOT] = 1'b1;
               // [R8] over-current watched during ramp too
               end else if (oc_event_i) begin
                  top_next.state = bss_pkg::BSS_HICCUP;
                  top_next.oc_fault = 1'b1;
                  top_next.hiccup_cnt = '0;
                  event_set[`BSS_EV_OC] = 1'b1;
               end else if (top_reg.state == bss_pkg::BSS_RAMP &&
                            seq.ss_level == `BSS_SS_FINAL_MV) begin
                  top_next.state = bss_pkg::BSS_RUN;
                  event_set[`BSS_EV_DONE] = 1'b1;
               end
            end
            bss_pkg::BSS_HICCUP: begin
               // [R12] blanking then clear and retry
               if (top_reg.hiccup_cnt == 19'(HICCUP_CYC - 1)) begin
                  top_next.state = bss_pkg::BSS_RAMP;
                  top_next.oc_fault = 1'b0;
                  top_next.hiccup_cnt = '0;
               end else begin
                  top_next.hiccup_cnt = top_reg.hiccup_cnt + 19'h00001;
               end
            end
            bss_pkg::BSS_THERMAL: begin
               // [R13] automatic restart when cool
               if (!overtemp_i) begin
                  top_next.state = bss_pkg::BSS_RAMP;
               end
            end
            default: begin
               top_next.state = bss_pkg::BSS_LOCKOUT;
            end
         endcase
      end

      active_next = (top_next.state == bss_pkg::BSS_RAMP) ||
                    (top_next.state == bss_pkg::BSS_RUN);
      // [R1] drivers gated by state; high side also by over-voltage fault
      top_next.hs_on = active_next & hs_pwm_i & !top_next.ovp_fault;
      // [R3] low side waits for first high-side pulse
      top_next.ls_on = active_next & seq.pb_ls_allow & !hs_pwm_i;
      top_next.ls_eighths = seq.pb_eighths;

      // [R7] tracking window of the reference
      top_next.ramping = (seq.ss_level >= `BSS_TRACK_LO_MV) &&
                         (seq.ss_level <= `BSS_TRACK_HI_MV);

      // Register port: read of status clears it, but a new event wins.
      top_next.rdata = '0;
      if (reg_re_i) begin
         unique case (reg_addr_i)
            `BSS_ADDR_STATUS: top_next.rdata = 16'(top_reg.status);
            `BSS_ADDR_MASK: top_next.rdata = 16'(top_reg.mask);
            `BSS_ADDR_STATE: top_next.rdata = 16'({seq.pb_done, top_reg.oc_sel,
               top_reg.ovp_fault, top_reg.oc_fault, top_reg.valid, top_reg.state});
            default: top_next.rdata = '0;
         endcase
      end
      if (reg_re_i && reg_addr_i == `BSS_ADDR_STATUS) begin
         top_next.status = event_set;
      end else begin
         top_next.status = top_reg.status | event_set;
      end
      if (reg_we_i && reg_addr_i == `BSS_ADDR_MASK) begin
         top_next.mask = reg_wdata_i[`BSS_EV_W-1:0];
      end
      top_next.irq = |(top_next.status & top_next.mask);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         top_reg <= RST;
      end else begin
         top_reg <= top_next;
      end
   end

   assign reg_rdata_o = top_reg.rdata;
   assign irq_o = top_reg.irq;
   assign high_side_switch_o = top_reg.hs_on;
   assign low_side_switch_o = top_reg.ls_on;
   assign low_side_eighths_o = top_reg.ls_eighths;
   assign supply_valid_o = top_reg.valid;
   assign output_ramping_o = top_reg.ramping;
   assign oc_fault_o = top_reg.oc_fault;
   assign ovp_fault_o = top_reg.ovp_fault;
   assign trip_level_select_o = top_reg.oc_sel;
   assign gate_bias_high_o = top_reg.bias_hi;

   // Consecutive cycles with the output above the over-voltage level.
   logic [5:0] above_run;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         above_run <= '0;
      end else if (!ovp_above_i) begin
         above_run <= '0;
      end else if (above_run != 6'h3F) begin
         above_run <= above_run + 6'h01;
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence hot_two;
      overtemp_i ##1 overtemp_i;
   endsequence

   sequence hiccup_done;
      top_reg.state == bss_pkg::BSS_HICCUP && top_reg.hiccup_cnt == 19'(HICCUP_CYC - 1)
      && supply_ok ##1 top_reg.state == bss_pkg::BSS_RAMP;
   endsequence

   lockout_off_a: assert property ( // [R1]
      !supply_ok |=> !high_side_switch_o && !low_side_switch_o && !supply_valid_o)
      else $error("driver on during lockout");

   valid_start_a: assert property ( // [R2]
      $rose(supply_valid_o) |-> top_reg.state == bss_pkg::BSS_RAMP
      && seq.ss_run && seq.ss_level == `BSS_SS_ZERO_MV)
      else $error("soft-start did not begin on supply valid");

   ls_wait_a: assert property ( // [R3]
      low_side_switch_o |-> $past(seq.pb_ls_allow) && !$past(hs_pwm_i))
      else $error("low side on before first high-side pulse");

   ramp_window_a: assert property ( // [R7]
      output_ramping_o == ($past(seq.ss_level) >= `BSS_TRACK_LO_MV &&
                           $past(seq.ss_level) <= `BSS_TRACK_HI_MV))
      else $error("ramping flag disagrees with soft-start level");

   oc_in_ramp_a: assert property ( // [R8]
      top_reg.state == bss_pkg::BSS_RAMP && oc_event_i && !overtemp_i && supply_ok
      |=> oc_fault_o ##1 seq.ss_level == `BSS_SS_ZERO_MV)
      else $error("over-current missed during soft-start");

   ovp_delay_a: assert property ( // [R9]
      $rose(ovp_fault_o) |-> above_run == 6'(OVP_CYC))
      else $error("over-voltage flag timing wrong");

   trip_select_a: assert property ( // [R10]
      1'b1 |=> trip_level_select_o == ($past(trip_pin_high_i) ? `BSS_OC_HIGH :
               ($past(trip_pin_low_i) ? `BSS_OC_LOW : `BSS_OC_MID)))
      else $error("trip level select wrong");

   gate_bias_a: assert property ( // [R11]
      light_load_i |=> !gate_bias_high_o)
      else $error("high gate bias at light load");

   hiccup_len_a: assert property ( // [R12]
      $fell(oc_fault_o) && supply_valid_o
      |-> $past(top_reg.hiccup_cnt) == 19'(HICCUP_CYC - 1))
      else $error("hiccup ended early");

   hiccup_retry_a: assert property ( // [R12]
      hiccup_done |-> !oc_fault_o && seq.ss_run && seq.ss_level == `BSS_SS_ZERO_MV)
      else $error("no retry after hiccup");

   thermal_off_a: assert property ( // [R13]
      hot_two |=> !high_side_switch_o && !low_side_switch_o
      && seq.ss_level == `BSS_SS_ZERO_MV)
      else $error("switching or level kept during over-temperature");

   supply_loss_a: assert property ( // [R14]
      $fell(supply_valid_o) |=> seq.ss_level == `BSS_SS_ZERO_MV
      && seq.pb_eighths == `BSS_PB_FIRST_STEP)
      else $error("supply loss did not reset the sequence");
endmodule

/* File: testbench/bss_stage_model.sv */
// Power stage model: switching period pulses and high-side gate requests.
module bss_stage_model #(
   parameter int PERIOD = 20
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Gate request enable and stage timing.
   input wire logic hs_en_i,
   output logic period_start_o,
   output logic hs_pwm_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // The gate request sits in the first half of every period once enabled.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 0;
         period_start_o <= 1'b0;
         hs_pwm_o <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         period_start_o <= (cnt == PERIOD - 1);
         hs_pwm_o <= hs_en_i && (cnt < PERIOD / 2);
      end
   end
endmodule

/* File: testbench/bss_top_bench.sv */
// Self-checking bench of the buck start-up sequencer.
module bss_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic bias_ok = 1'b0, enable_ok = 1'b0, overtemp = 1'b0, ovp_above = 1'b0;
   logic oc_event = 1'b0, light_load = 1'b0, trip_hi = 1'b0, trip_lo = 1'b0;
   logic we = 1'b0, re = 1'b0, hs_en = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic period_start, hs_pwm, irq, hs_sw, ls_sw, valid, ramping, oc_f, ovp_f, gbias;
   logic [15:0] rdata, d;
   logic [3:0] eighths, prev;
   logic [1:0] trip_sel;
   int fail_count = 0, num_checks = 0, cyc = 0, pulses = 0, n, t0, p0, bad;

   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   always @(posedge ref_clk) if (period_start) pulses <= pulses + 1;

   bss_top #(.HICCUP_CYC(200)) u_dut (
      .ref_clk_i(ref_clk), .resetn_i(resetn), .bias_ok_i(bias_ok), .enable_ok_i(enable_ok),
      .overtemp_i(overtemp), .ovp_above_i(ovp_above), .oc_event_i(oc_event),
      .period_start_i(period_start), .hs_pwm_i(hs_pwm), .light_load_i(light_load),
      .trip_pin_high_i(trip_hi), .trip_pin_low_i(trip_lo), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq),
      .high_side_switch_o(hs_sw), .low_side_switch_o(ls_sw), .low_side_eighths_o(eighths),
      .supply_valid_o(valid), .output_ramping_o(ramping), .oc_fault_o(oc_f),
      .ovp_fault_o(ovp_f), .trip_level_select_o(trip_sel), .gate_bias_high_o(gbias)
   );
   bss_stage_model u_stage (
      .clk_i(ref_clk), .resetn_i(resetn), .hs_en_i(hs_en),
      .period_start_o(period_start), .hs_pwm_o(hs_pwm)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Ends the run when a wait used up its bound.
   task automatic bound(input int lim);
      if (n >= lim) begin
         fail_count++;
         $display("[ERR] t=%0t wait=%h limit=%h", $time, n, lim);
         stop_test();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      we <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      re <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      re <= 1'b0;
      @(negedge ref_clk);
      v = rdata;
   endtask
   task automatic settle();
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      bias_ok <= 1'b1;
      settle();
      settle();
      chk({hs_sw, ls_sw, valid}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         trip_hi <= (i == 0 || i == 3);
         trip_lo <= (i >= 2);
         light_load <= i[0];
         settle();
         chk(trip_sel, (i == 1) ? 16'h0001 : (i == 2) ? 16'h0000 : 16'h0002);
         chk(gbias, !i[0]);
      end
      @(posedge ref_clk);
      enable_ok <= 1'b1;
      for (n = 0; n < 10 && valid !== 1'b1; n++) @(negedge ref_clk);
      t0 = cyc;
      chk(n, 16'h0002);
      chk(irq, 16'h0000);
      rd(4'h0, d);
      chk(d & 16'h001F, 16'h0001);
      rd(4'h8, d);
      chk(d & 16'h001F, 16'h0002);
      bad = 0;
      for (n = 0; n < 100; n++) begin
         @(negedge ref_clk);
         if (ls_sw !== 1'b0) bad++;
      end
      chk(bad, 16'h0000);
      @(posedge ref_clk);
      hs_en <= 1'b1;
      for (n = 0; n < 100 && eighths !== 4'h1; n++) @(negedge ref_clk);
      chk(eighths, 16'h0001);
      for (int s = 2; s <= 8; s++) begin
         prev = eighths;
         for (n = 0; n < 500 && eighths === prev; n++) @(negedge ref_clk);
         bound(500);
         chk(eighths, prev + 4'h1);
         if (s > 2) chk(16'(pulses - p0), 16'h0010);
         p0 = pulses;
      end
      bad = 0;
      for (n = 0; n < 400; n++) begin
         @(negedge ref_clk);
         if (ls_sw === 1'b1) bad++;
      end
      chk(bad != 0, 16'h0001);
      chk(eighths, 16'h0008);
      rd(4'h8, d);
      chk(d & 16'h0400, 16'h0400);
      rd(4'h0, d);
      wr(4'h4, 16'h0004);
      rd(4'h4, d);
      chk(d, 16'h0004);
      rd(4'hC, d);
      chk(d, 16'h0000);
      @(posedge ref_clk);
      ovp_above <= 1'b1;
      repeat (30) @(posedge ref_clk);
      ovp_above <= 1'b0;
      settle();
      chk(ovp_f, 16'h0000);
      @(posedge ref_clk);
      ovp_above <= 1'b1;
      for (n = 0; n < 60 && ovp_f !== 1'b1; n++) @(negedge ref_clk);
      chk(n >= 51 && n <= 52, 16'h0001);
      settle();
      chk({hs_sw, irq}, 16'h0001);
      rd(4'h0, d);
      chk(d & 16'h001F, 16'h0004);
      settle();
      chk(irq, 16'h0000);
      @(posedge ref_clk);
      ovp_above <= 1'b0;
      for (n = 0; n < 10 && ovp_f !== 1'b0; n++) @(negedge ref_clk);
      chk(n, 16'h0002);
      for (n = 0; n < 9000 && ramping !== 1'b1; n++) @(negedge ref_clk);
      chk(cyc - t0 >= 7390 && cyc - t0 <= 7610, 16'h0001);
      t0 = cyc;
      for (n = 0; n < 31000 && ramping !== 1'b0; n++) @(negedge ref_clk);
      chk(cyc - t0 >= 30090 && cyc - t0 <= 30110, 16'h0001);
      @(posedge ref_clk);
      oc_event <= 1'b1;
      @(posedge ref_clk);
      oc_event <= 1'b0;
      @(negedge ref_clk);
      chk({oc_f, hs_sw, ls_sw}, 16'h0004);
      for (n = 0; n < 300 && oc_f !== 1'b0; n++) @(negedge ref_clk);
      chk(n >= 197 && n <= 202, 16'h0001);
      t0 = cyc;
      for (n = 0; n < 9000 && ramping !== 1'b1; n++) @(negedge ref_clk);
      chk(cyc - t0 >= 7390 && cyc - t0 <= 7610, 16'h0001);
      @(posedge ref_clk);
      overtemp <= 1'b1;
      settle();
      settle();
      settle();
      chk({hs_sw, ls_sw, ramping}, 16'h0000);
      rd(4'h8, d);
      chk(d & 16'h001F, 16'h0010);
      rd(4'h0, d);
      chk(d & 16'h0008, 16'h0008);
      @(posedge ref_clk);
      overtemp <= 1'b0;
      settle();
      settle();
      rd(4'h8, d);
      chk(d & 16'h001F, 16'h0002);
      @(posedge ref_clk);
      enable_ok <= 1'b0;
      hs_en <= 1'b0;
      settle();
      settle();
      chk({valid, hs_sw, ls_sw, ramping}, 16'h0000);
      rd(4'h8, d);
      chk(d & 16'h041F, 16'h0001);
      @(posedge ref_clk);
      enable_ok <= 1'b1;
      bad = 0;
      for (n = 0; n < 60; n++) begin
         @(negedge ref_clk);
         if (ls_sw !== 1'b0) bad++;
      end
      chk(bad, 16'h0000);
      rd(4'h8, d);
      chk(d & 16'h0420, 16'h0020);
      stop_test();
   end
endmodule
